/* File: common/sched_pkg.sv */
package sched_pkg;
	localparam int NUM_WIN = 20;
	localparam int NUM_TIMER = 20;
	localparam int NUM_DAY = 8;
	localparam int ACC_SLOTS = 128;
	localparam int MIN_W = 11;
	localparam int WNUM_W = 5;
	localparam int WIN_W = 2 * MIN_W;
	localparam int TMR_W = MIN_W + 8;
	localparam int CNT_W = 13;
	localparam int RND_W = 11;
	localparam logic [2:0] HOL_DAY = 3'h7;
	localparam int SEC_PER_MIN = 60;
	localparam int HOUR_S = 3600;
	localparam int STEP_S = 4 * SEC_PER_MIN;
	localparam int RAND_SPAN_S = 30 * SEC_PER_MIN;
	localparam int BEEP_SLOW_S = 15;
	localparam int BEEP_FAST_S = 5;
	localparam int WARN_FAST_S = 60;
	localparam logic [3:0] NO_AUTO_DIS = 4'hF;
	localparam logic [1:0] EXT_ONE_H = 2'h1;
	localparam logic [1:0] EXT_TWO_H = 2'h2;
	localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
	localparam logic [7:0] ADDR_WIN_BASE = 8'h00;
	localparam logic [7:0] ADDR_DAY_BASE = 8'h20;
	localparam logic [7:0] ADDR_CFG = 8'h28;
	localparam logic [7:0] ADDR_STAT = 8'h29;
	localparam logic [7:0] ADDR_RELAY = 8'h2A;
	localparam logic [7:0] ADDR_TMR_BASE = 8'h40;
	localparam logic [7:0] ADDR_ACC_BASE = 8'h80;
	localparam int WIN_STOP_LSB = 16;
	localparam int DAY_OPEN_LSB = 0;
	localparam int DAY_CLOSE_LSB = 8;
	localparam int TMR_DAYS_LSB = 16;
	localparam int TMR_EN_BIT = 31;
	localparam int CFG_GRACE_LSB = 0;
	localparam int CFG_WARN_LSB = 4;
	localparam int CFG_DIS_LSB = 8;
	localparam int CFG_FORCE_BIT = 12;
	localparam int CFG_EXC_BIT = 13;
	localparam int CFG_RESTR_BIT = 14;
	localparam int CFG_ALARM_BIT = 15;
	localparam int RELAY_MODE_LSB = 8;
	localparam logic [15:0] CFG_RST = 16'h0000;
	typedef enum logic [1:0] {
		A_IDLE = 2'b00, A_EXT = 2'b01, A_GRACE = 2'b10, A_WARN = 2'b11
	} arm_state_type;
	typedef enum logic [2:0] {
		R_OFF = 3'b000, R_START = 3'b001, R_END = 3'b010, R_SPAN = 3'b011,
		R_BOTH = 3'b100, R_RSTART = 3'b101, R_REND = 3'b110, R_RSPAN = 3'b111
	} relay_mode_type;
endpackage

/* File: logic/window_check.sv */
`timescale 1ns/1ps
`default_nettype none
module window_check
	import sched_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic valid_i,
	input wire logic [MIN_W-1:0] start_i,
	input wire logic [MIN_W-1:0] stop_i,
	input wire logic [MIN_W-1:0] minute_i,
	output logic inside_o,
	output logic start_o,
	output logic end_o
);
	logic prev_ff;

	// Wraps past midnight when stop precedes start
	assign inside_o = valid_i && ((start_i <= stop_i) ?
		(minute_i >= start_i && minute_i < stop_i) :
		(minute_i >= start_i || minute_i < stop_i));
	assign start_o = inside_o && !prev_ff;
	assign end_o = !inside_o && prev_ff;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			prev_ff <= 1'b0;
		else
			prev_ff <= inside_o;
	end
endmodule // window_check
`default_nettype wire

/* File: logic/relay_event.sv */
`timescale 1ns/1ps
`default_nettype none
module relay_event
	import sched_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sec_tick_i,
	input wire logic inside_i,
	input wire logic start_i,
	input wire logic end_i,
	input wire logic [2:0] mode_i,
	output logic relay_o,
	output logic pulse_o
);
	logic [15:0] lfsr_ff;
	logic [RND_W-1:0] cnt_ff;
	logic pend_ff;
	logic pend_on_ff;
	logic [RND_W-1:0] rnd;
	relay_mode_type mode;

	assign mode = relay_mode_type'(mode_i);
	assign rnd = RND_W'(int'(lfsr_ff) % RAND_SPAN_S);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			lfsr_ff <= 16'hACE1;
		else
			lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^
				lfsr_ff[12] ^ lfsr_ff[10]};
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			relay_o <= 1'b0;
			pulse_o <= 1'b0;
			pend_ff <= 1'b0;
			pend_on_ff <= 1'b0;
			cnt_ff <= '0;
		end
		else
		begin
			pulse_o <= 1'b0;
			if (mode == R_SPAN)
				relay_o <= inside_i;
			else if (mode != R_RSPAN)
				relay_o <= 1'b0;
			if (pend_ff && sec_tick_i)
			begin
				if (cnt_ff == '0)
				begin
					pend_ff <= 1'b0;
					if (mode == R_RSPAN)
						relay_o <= pend_on_ff;
					else
						pulse_o <= 1'b1;
				end
				else
					cnt_ff <= cnt_ff - RND_W'(1);
			end
			// An edge that the mode times randomly (start in R_RSTART/R_RSPAN, end in R_REND/R_RSPAN) restarts the pending event
			if (start_i)
			begin
				if (mode == R_START || mode == R_BOTH)
					pulse_o <= 1'b1;
				if (mode == R_RSTART || mode == R_RSPAN)
				begin
					pend_ff <= 1'b1;
					pend_on_ff <= 1'b1;
					cnt_ff <= rnd;
				end
			end
			if (end_i)
			begin
				if (mode == R_END || mode == R_BOTH)
					pulse_o <= 1'b1;
				if (mode == R_REND || mode == R_RSPAN)
				begin
					pend_ff <= 1'b1;
					pend_on_ff <= 1'b0;
					cnt_ff <= rnd;
				end
			end
		end
	end
endmodule // relay_event
`default_nettype wire

/* File: logic/partition_arm_scheduler.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module partition_arm_scheduler
	import sched_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic sec_tick_i,
	input wire logic [MIN_W-1:0] rtc_minute_i,
	input wire logic [2:0] rtc_weekday_i,
	input wire logic rtc_holiday_i,
	input wire logic arm_req_i,
	input wire logic disarm_req_i,
	input wire logic ext_req_i,
	input wire logic [1:0] ext_hours_i,
	input wire logic user_limited_i,
	input wire logic [2:0] user_sched_i,
	input wire logic oper_level_i,
	input wire logic in_alarm_i,
	input wire logic fault_present_i,
	output logic armed_o,
	output logic arm_away_o,
	output logic disarm_o,
	output logic bypass_o,
	output logic arm_skipped_o,
	output logic warn_alert_o,
	output logic beep_o,
	output logic access_denied_o,
	output logic disarm_refused_o,
	output logic rpt_open_o,
	output logic rpt_close_o,
	output logic rpt_fail_open_o,
	output logic rpt_fail_close_o,
	output logic relay_o,
	output logic relay_pulse_o,
	output logic [NUM_TIMER-1:0] timer_out_o
);
	////////////////////////////////////////////////////////////////////////
	logic [WIN_W-1:0] win_ff [NUM_WIN];
	logic [15:0] day_ff [NUM_DAY];
	logic [WNUM_W-1:0] acc_ff [ACC_SLOTS];
	logic [TMR_W-1:0] tmr_ff [NUM_TIMER];
	logic [15:0] cfg_ff;
	logic [15:0] relay_cfg_ff;
	logic [31:0] rd_val;
	logic [MIN_W-1:0] min_prev_ff;
	arm_state_type arm_st_ff, nxt_arm_st;
	logic [CNT_W-1:0] sec_cnt_ff, nxt_sec_cnt;
	logic [CNT_W-1:0] dis_cnt_ff;
	logic dis_busy_ff;
	logic [1:0] ext_ff;
	logic armed_ff;
	logic arm_fire, to_grace, to_warn, tick_done;
	logic [3:0] grace_cfg, warn_cfg, dis_cfg;
	logic force_en, exc_en, restr_en, alarm_en;
	logic [4:0] win_idx;
	logic [2:0] day_widx;
	logic [6:0] acc_idx;
	logic [4:0] tmr_idx;
	logic [2:0] day_idx;
	logic [WIN_W:0] open_w, close_w, relay_w;
	logic in_open, in_close, open_end, close_end;
	logic rl_in, rl_start, rl_end;
	logic [1:0] acc_in;
	logic user_ok, dis_allowed, ext_ok, man_arm_ok, man_dis_ok;
	logic auto_arm_now, auto_dis_now, beep_now;
	logic [NUM_TIMER-1:0] tmr_hit;

	function automatic logic in_range(input logic [7:0] a,
		input logic [7:0] base, input int n);
		in_range = (a >= base) && (int'(a) < int'(base) + n);
	endfunction

	function automatic logic [WIN_W:0] win_lookup(input logic [4:0] n);
		win_lookup = '0;
		if (n != '0 && int'(n) <= NUM_WIN)
			win_lookup = {1'b1, win_ff[n - 5'h1]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register port
	assign win_idx = 5'(addr_i - ADDR_WIN_BASE);
	assign day_widx = 3'(addr_i - ADDR_DAY_BASE);
	assign acc_idx = 7'(addr_i - ADDR_ACC_BASE);
	assign tmr_idx = 5'(addr_i - ADDR_TMR_BASE);

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < NUM_WIN; i++)
				win_ff[i] <= '0;
			for (int i = 0; i < NUM_DAY; i++)
				day_ff[i] <= '0;
			for (int i = 0; i < ACC_SLOTS; i++)
				acc_ff[i] <= '0;
			for (int i = 0; i < NUM_TIMER; i++)
				tmr_ff[i] <= '0;
			cfg_ff <= CFG_RST;
			relay_cfg_ff <= '0;
		end
		else if (wr_i)
		begin
			if (in_range(addr_i, ADDR_WIN_BASE, NUM_WIN))
				win_ff[win_idx] <= {wdata_i[WIN_STOP_LSB +: MIN_W],
					wdata_i[MIN_W-1:0]};
			if (in_range(addr_i, ADDR_DAY_BASE, NUM_DAY))
				day_ff[day_widx] <= wdata_i[15:0];
			if (in_range(addr_i, ADDR_ACC_BASE, ACC_SLOTS))
				acc_ff[acc_idx] <= wdata_i[WNUM_W-1:0];
			if (in_range(addr_i, ADDR_TMR_BASE, NUM_TIMER))
				tmr_ff[tmr_idx] <= {wdata_i[TMR_EN_BIT],
					wdata_i[TMR_DAYS_LSB +: 7], wdata_i[MIN_W-1:0]};
			if (addr_i == ADDR_CFG)
				cfg_ff <= wdata_i[15:0];
			if (addr_i == ADDR_RELAY)
				relay_cfg_ff <= wdata_i[15:0];
		end
	end

	always_comb
	begin
		rd_val = '0;
		if (in_range(addr_i, ADDR_WIN_BASE, NUM_WIN))
		begin
			rd_val[MIN_W-1:0] = win_ff[win_idx][MIN_W-1:0];
			rd_val[WIN_STOP_LSB +: MIN_W] = win_ff[win_idx][MIN_W +: MIN_W];
		end
		if (in_range(addr_i, ADDR_DAY_BASE, NUM_DAY))
			rd_val[15:0] = day_ff[day_widx];
		if (in_range(addr_i, ADDR_ACC_BASE, ACC_SLOTS))
			rd_val[WNUM_W-1:0] = acc_ff[acc_idx];
		if (in_range(addr_i, ADDR_TMR_BASE, NUM_TIMER))
		begin
			rd_val[MIN_W-1:0] = tmr_ff[tmr_idx][MIN_W-1:0];
			rd_val[TMR_DAYS_LSB +: 7] = tmr_ff[tmr_idx][MIN_W +: 7];
			rd_val[TMR_EN_BIT] = tmr_ff[tmr_idx][TMR_W-1];
		end
		if (addr_i == ADDR_CFG)
			rd_val[15:0] = cfg_ff;
		if (addr_i == ADDR_RELAY)
			rd_val[15:0] = relay_cfg_ff;
		if (addr_i == ADDR_STAT)
			rd_val[8:0] = {ext_ff, arm_st_ff, dis_busy_ff, armed_ff,
				in_open, in_close, warn_alert_o};
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			rdata_o <= '0;
		else
			rdata_o <= rd_i ? rd_val : '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Schedules and windows
	assign grace_cfg = cfg_ff[CFG_GRACE_LSB +: 4];
	assign warn_cfg = cfg_ff[CFG_WARN_LSB +: 4];
	assign dis_cfg = cfg_ff[CFG_DIS_LSB +: 4];
	assign force_en = cfg_ff[CFG_FORCE_BIT];
	assign exc_en = cfg_ff[CFG_EXC_BIT];
	assign restr_en = cfg_ff[CFG_RESTR_BIT];
	assign alarm_en = cfg_ff[CFG_ALARM_BIT];
	assign day_idx = rtc_holiday_i ? HOL_DAY : rtc_weekday_i;
	// Lookups follow window table writes too
	always_comb
	begin
		open_w = win_lookup(day_ff[day_idx][DAY_OPEN_LSB +: WNUM_W]);
		close_w = win_lookup(day_ff[day_idx][DAY_CLOSE_LSB +: WNUM_W]);
		relay_w = win_lookup(relay_cfg_ff[WNUM_W-1:0]);
	end

	window_check u_open (.clk_i(clk_i), .srst_i(srst_i),
		.valid_i(open_w[WIN_W]), .start_i(open_w[MIN_W-1:0]),
		.stop_i(open_w[MIN_W +: MIN_W]), .minute_i(rtc_minute_i),
		.inside_o(in_open), .start_o(), .end_o(open_end));
	window_check u_close (.clk_i(clk_i), .srst_i(srst_i),
		.valid_i(close_w[WIN_W]), .start_i(close_w[MIN_W-1:0]),
		.stop_i(close_w[MIN_W +: MIN_W]), .minute_i(rtc_minute_i),
		.inside_o(in_close), .start_o(), .end_o(close_end));
	window_check u_relay (.clk_i(clk_i), .srst_i(srst_i),
		.valid_i(relay_w[WIN_W]), .start_i(relay_w[MIN_W-1:0]),
		.stop_i(relay_w[MIN_W +: MIN_W]), .minute_i(rtc_minute_i),
		.inside_o(rl_in), .start_o(rl_start), .end_o(rl_end));

	for (genvar k = 0; k < 2; k++)
	begin : g_acc
		logic [WIN_W:0] aw;
		always_comb
			aw = win_lookup(acc_ff[{user_sched_i, day_idx, 1'(k)}]);
		window_check u_acc (.clk_i(clk_i), .srst_i(srst_i),
			.valid_i(aw[WIN_W]), .start_i(aw[MIN_W-1:0]),
			.stop_i(aw[MIN_W +: MIN_W]), .minute_i(rtc_minute_i),
			.inside_o(acc_in[k]), .start_o(), .end_o());
	end

	relay_event u_event (.clk_i(clk_i), .srst_i(srst_i),
		.sec_tick_i(sec_tick_i), .inside_i(rl_in), .start_i(rl_start),
		.end_i(rl_end), .mode_i(relay_cfg_ff[RELAY_MODE_LSB +: 3]),
		.relay_o(relay_o), .pulse_o(relay_pulse_o));

	////////////////////////////////////////////////////////////////////////
	// User timers
	for (genvar t = 0; t < NUM_TIMER; t++)
	begin : g_tmr
		assign tmr_hit[t] = tmr_ff[t][TMR_W-1] &&
			tmr_ff[t][MIN_W + int'(rtc_weekday_i)] &&
			tmr_ff[t][MIN_W-1:0] == rtc_minute_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			min_prev_ff <= '0;
			timer_out_o <= '0;
		end
		else
		begin
			min_prev_ff <= rtc_minute_i;
			timer_out_o <= (rtc_minute_i != min_prev_ff) ? tmr_hit : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Keypad requests
	assign user_ok = !user_limited_i || (|acc_in);
	assign dis_allowed = !restr_en || !oper_level_i || in_open ||
		in_close || (alarm_en && in_alarm_i);
	assign ext_ok = ext_req_i && user_ok &&
		(ext_hours_i == EXT_ONE_H || ext_hours_i == EXT_TWO_H);
	assign man_arm_ok = arm_req_i && user_ok && !armed_ff;
	assign man_dis_ok = disarm_req_i && user_ok && armed_ff && dis_allowed;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ext_ff <= '0;
		else if (ext_ok)
			ext_ff <= ext_hours_i;
		else if (arm_st_ff == A_IDLE && close_end)
			ext_ff <= '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Auto-arm sequence, counted in RTC seconds
	assign tick_done = sec_tick_i && sec_cnt_ff == CNT_ONE;

	always_comb
	begin
		nxt_arm_st = arm_st_ff;
		nxt_sec_cnt = sec_cnt_ff;
		arm_fire = 1'b0;
		to_grace = 1'b0;
		to_warn = 1'b0;
		unique case (arm_st_ff)
			A_IDLE:
				if (close_end && !armed_ff)
				begin
					if (ext_ff != '0)
					begin
						nxt_arm_st = A_EXT;
						nxt_sec_cnt = CNT_W'(int'(ext_ff) * HOUR_S);
					end
					else
						to_grace = 1'b1;
				end
			A_EXT:
				to_grace = tick_done;
			A_GRACE:
				to_warn = tick_done;
			A_WARN:
				arm_fire = tick_done;
		endcase
		if (sec_tick_i && arm_st_ff != A_IDLE)
			nxt_sec_cnt = sec_cnt_ff - CNT_ONE;
		if (to_grace)
		begin
			if (grace_cfg != '0)
			begin
				nxt_arm_st = A_GRACE;
				nxt_sec_cnt = CNT_W'(int'(grace_cfg) * STEP_S);
			end
			else
				to_warn = 1'b1;
		end
		if (to_warn)
		begin
			if (warn_cfg != '0)
			begin
				nxt_arm_st = A_WARN;
				nxt_sec_cnt = CNT_W'(int'(warn_cfg) * SEC_PER_MIN);
			end
			else
				arm_fire = 1'b1;
		end
		if (arm_fire)
			nxt_arm_st = A_IDLE;
		// Manual arm during the sequence cancels it
		if (armed_ff)
			nxt_arm_st = A_IDLE;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			arm_st_ff <= A_IDLE;
			sec_cnt_ff <= '0;
		end
		else
		begin
			arm_st_ff <= nxt_arm_st;
			sec_cnt_ff <= nxt_sec_cnt;
		end
	end

	assign auto_arm_now = arm_fire && !armed_ff &&
		(!fault_present_i || force_en);
	assign beep_now = sec_tick_i && arm_st_ff == A_WARN &&
		((int'(sec_cnt_ff) <= WARN_FAST_S) ?
		(int'(sec_cnt_ff) % BEEP_FAST_S == 0) :
		(int'(sec_cnt_ff) % BEEP_SLOW_S == 0));
	assign warn_alert_o = arm_st_ff == A_WARN;

	////////////////////////////////////////////////////////////////////////
	// Auto-disarm
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			dis_busy_ff <= 1'b0;
			dis_cnt_ff <= '0;
		end
		else if (open_end && armed_ff && dis_cfg != NO_AUTO_DIS &&
			dis_cfg != '0)
		begin
			dis_busy_ff <= 1'b1;
			dis_cnt_ff <= CNT_W'(int'(dis_cfg) * STEP_S);
		end
		else if (dis_busy_ff && sec_tick_i)
		begin
			dis_cnt_ff <= dis_cnt_ff - CNT_ONE;
			if (dis_cnt_ff == CNT_ONE)
				dis_busy_ff <= 1'b0;
		end
	end

	assign auto_dis_now = armed_ff && ((open_end && dis_cfg == '0) ||
		(dis_busy_ff && sec_tick_i && dis_cnt_ff == CNT_ONE));

	////////////////////////////////////////////////////////////////////////
	// Arm state, actions and reports
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			armed_ff <= 1'b0;
		else if (auto_arm_now || man_arm_ok)
			armed_ff <= 1'b1;
		else if (auto_dis_now || man_dis_ok)
			armed_ff <= 1'b0;
	end
	assign armed_o = armed_ff;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			arm_away_o <= 1'b0;
			disarm_o <= 1'b0;
			bypass_o <= 1'b0;
			arm_skipped_o <= 1'b0;
			beep_o <= 1'b0;
			access_denied_o <= 1'b0;
			disarm_refused_o <= 1'b0;
			rpt_open_o <= 1'b0;
			rpt_close_o <= 1'b0;
			rpt_fail_open_o <= 1'b0;
			rpt_fail_close_o <= 1'b0;
		end
		else
		begin
			arm_away_o <= auto_arm_now || man_arm_ok;
			disarm_o <= (auto_dis_now || man_dis_ok) &&
				!(auto_arm_now || man_arm_ok);
			bypass_o <= auto_arm_now && fault_present_i;
			arm_skipped_o <= arm_fire && !armed_ff && fault_present_i &&
				!force_en && !man_arm_ok;
			beep_o <= beep_now;
			access_denied_o <= (arm_req_i || disarm_req_i || ext_req_i) &&
				!user_ok;
			disarm_refused_o <= disarm_req_i && user_ok && !dis_allowed;
			rpt_close_o <= auto_arm_now ||
				(man_arm_ok && !(exc_en && in_close));
			rpt_open_o <= auto_dis_now ||
				(man_dis_ok && !(exc_en && (in_open || in_close)));
			rpt_fail_open_o <= open_end && armed_ff;
			rpt_fail_close_o <= close_end && !armed_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_warn_done;
		arm_st_ff == A_WARN && sec_tick_i && sec_cnt_ff == CNT_ONE;
	endsequence

	a_arm_warn_end: assert property (
		s_warn_done ##0 ((!fault_present_i || force_en) && !armed_ff) |=>
		armed_ff && arm_away_o)
		else $error("No arm at end of warning");
	a_skip_no_force: assert property (
		arm_fire && fault_present_i && !force_en && !armed_ff &&
		!arm_req_i |=> !armed_ff && arm_skipped_o)
		else $error("Faulted auto-arm not skipped");
	a_force_bypass: assert property (
		bypass_o |-> arm_away_o && armed_ff)
		else $error("Bypass without arming");
	a_warn_zero: assert property (
		arm_st_ff == A_WARN |-> warn_cfg != '0)
		else $error("Warning run with zero setting");
	a_beep_in_warn: assert property (
		beep_o |-> $past(arm_st_ff) == A_WARN)
		else $error("Beep outside warning");
	a_fast_beep: assert property (
		arm_st_ff == A_WARN && sec_tick_i &&
		sec_cnt_ff == CNT_W'(BEEP_FAST_S) |=> beep_o)
		else $error("Missing final-minute beep");
	a_grace_load: assert property (
		arm_st_ff == A_IDLE && close_end && !armed_ff && ext_ff == '0 &&
		grace_cfg != '0 |=> arm_st_ff == A_GRACE &&
		sec_cnt_ff == CNT_W'(int'($past(grace_cfg)) * STEP_S))
		else $error("Grace delay not loaded");
	a_ext_refuse: assert property (
		ext_req_i && ext_hours_i != EXT_ONE_H && ext_hours_i != EXT_TWO_H &&
		!(arm_st_ff == A_IDLE && close_end) |=> $stable(ext_ff))
		else $error("Bad extension accepted");
	a_disarm_refused: assert property (
		disarm_req_i && user_ok && !dis_allowed && !auto_dis_now |=>
		disarm_refused_o && !disarm_o)
		else $error("Restricted disarm not refused");
	a_access_denied: assert property (
		(arm_req_i || disarm_req_i) && !user_ok |=> access_denied_o)
		else $error("Access denial missing");
	a_fail_close: assert property (
		close_end && !armed_ff |=> rpt_fail_close_o)
		else $error("Failed-to-close not reported");
	a_no_autodis: assert property (
		open_end && armed_ff && dis_cfg == NO_AUTO_DIS && !disarm_req_i
		|=> !dis_busy_ff && armed_ff)
		else $error("Auto-disarm with setting fifteen");
endmodule // partition_arm_scheduler
`default_nettype wire

/* File: test/keypad_model.sv */
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic beep_i,
	output logic arm_req_o,
	output logic disarm_req_o,
	output logic ext_req_o,
	output logic [1:0] ext_hours_o,
	output logic [7:0] beeps_o
);
	initial
	begin
		{arm_req_o, disarm_req_o, ext_req_o, ext_hours_o} = '0;
		beeps_o = '0;
	end
	// One-cycle press; hours idle inverted after release
	task automatic press(input logic [1:0] kind, input logic [1:0] hrs);
		@(posedge clk_i);
		arm_req_o <= kind == 2'h0;
		disarm_req_o <= kind == 2'h1;
		ext_req_o <= kind == 2'h2;
		ext_hours_o <= hrs;
		@(posedge clk_i);
		{arm_req_o, disarm_req_o, ext_req_o} <= 3'h0;
		ext_hours_o <= ~hrs;
	endtask
	// Sounder counts beeps
	always @(posedge clk_i)
		beeps_o <= clr_i ? 8'h00 : beeps_o + {7'h00, beep_i};
endmodule // keypad_model
`default_nettype wire

/* File: test/partition_arm_scheduler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
$display("FAIL %s exp %0h got %0h", nm, e, g); end end
module partition_arm_scheduler_tb;
	import sched_pkg::*;
	logic clk = 0, srst = 1, wr = 0, rd = 0, tick = 0, tick_en = 0, clr = 0;
	logic [7:0] addr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic [MIN_W-1:0] rmin = '0;
	logic lim = 0, oper = 1, alarm = 0, fault = 0;
	logic arq, drq, erq;
	logic [1:0] ehr;
	logic [7:0] beeps;
	logic armed, away, dis, byp, skip, den, ref_o, ro, rc, rfc;
	logic [12:0] seen = '0;
	logic beep, rfo, walert, rpul, hol = 0;
	logic [NUM_TIMER-1:0] tmr;
	int err_count = 0, n_tests = 0, ticks = 0, cycles = 0;
	always #5 clk = ~clk;
	partition_arm_scheduler partition_arm_scheduler_inst (.clk_i(clk),
		.srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .sec_tick_i(tick), .rtc_minute_i(rmin),
		.rtc_weekday_i(3'h0), .rtc_holiday_i(hol), .arm_req_i(arq),
		.disarm_req_i(drq), .ext_req_i(erq), .ext_hours_i(ehr),
		.user_limited_i(lim), .user_sched_i(3'h0), .oper_level_i(oper),
		.in_alarm_i(alarm), .fault_present_i(fault), .armed_o(armed),
		.arm_away_o(away), .disarm_o(dis), .bypass_o(byp),
		.arm_skipped_o(skip), .warn_alert_o(walert), .beep_o(beep),
		.access_denied_o(den), .disarm_refused_o(ref_o), .rpt_open_o(ro),
		.rpt_close_o(rc), .rpt_fail_open_o(rfo), .rpt_fail_close_o(rfc),
		.relay_o(), .relay_pulse_o(rpul), .timer_out_o(tmr));
	keypad_model keypad_model_inst (.clk_i(clk), .clr_i(clr), .beep_i(beep),
		.arm_req_o(arq), .disarm_req_o(drq), .ext_req_o(erq),
		.ext_hours_o(ehr), .beeps_o(beeps));
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		tick <= tick_en & ~tick;
		ticks <= clr ? 0 : ticks + (tick ? 1 : 0);
		seen <= clr ? '0 : seen | {|tmr, rpul, walert, rfo, ro, rc, rfc,
			ref_o, den, skip, byp, dis, away};
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			err_count++;
			summarize();
		end
	end
	task automatic summarize();
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	task automatic clear();
		@(posedge clk);
		clr <= 1;
		@(posedge clk);
		clr <= 0;
	endtask
	task automatic minute(input logic [MIN_W-1:0] m);
		@(posedge clk);
		rmin <= m;
		repeat (6) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 0;
		rreg(ADDR_STAT);
		`CHK("status", 32'h0, d)
		wreg(ADDR_WIN_BASE, 32'h0014000A);
		wreg(ADDR_DAY_BASE, 32'h00000100);
		rreg(ADDR_WIN_BASE);
		`CHK("window", 32'h0014000A, d)
		rreg(8'h14);
		`CHK("unmapped", 32'h0, d)
		wreg(ADDR_CFG, 32'h00000F00);
		fault <= 1;
		minute(11'd15);
		clear();
		minute(11'd20);
		`CHK("skipped", 3'b100, {seen[3], seen[0], seen[2]})
		`CHK("failclose", 1'b1, seen[6])
		wreg(ADDR_CFG, 32'h00001F21);
		minute(11'd15);
		clear();
		minute(11'd20);
		tick_en <= 1;
		while (seen[0] !== 1'b1 && cycles < 4000)
		begin
			@(posedge clk);
			#1;
		end
		tick_en <= 0;
		`CHK("ticks", 360, ticks)
		`CHK("beeps", 8'd16, beeps)
		`CHK("armbyp", 4'hF, {armed, seen[2], seen[7], seen[10]})
		wreg(ADDR_CFG, 32'h0000DF11);
		minute(11'd100);
		clear();
		keypad_model_inst.press(2'h1, 2'h0);
		minute(11'd100);
		`CHK("refuse", 3'b101, {seen[5], seen[1], armed})
		clear();
		alarm <= 1;
		keypad_model_inst.press(2'h1, 2'h0);
		minute(11'd100);
		`CHK("alarmdis", 3'b101, {seen[1], armed, seen[8]})
		clear();
		lim <= 1;
		keypad_model_inst.press(2'h0, 2'h0);
		minute(11'd100);
		`CHK("denied", 2'b10, {seen[4], armed})
		clear();
		lim <= 0;
		keypad_model_inst.press(2'h2, 2'h3);
		rreg(ADDR_STAT);
		`CHK("ext3", 2'h0, d[8:7])
		keypad_model_inst.press(2'h2, EXT_TWO_H);
		rreg(ADDR_STAT);
		`CHK("ext2", EXT_TWO_H, d[8:7])
		wreg(8'h01, 32'h0014000A);
		wreg(ADDR_DAY_BASE, 32'h00000002);
		wreg(ADDR_RELAY, 32'h00000401);
		wreg(ADDR_TMR_BASE, 32'h8001000F);
		keypad_model_inst.press(2'h0, 2'h0);
		hol <= 1;
		minute(11'd15);
		clear();
		minute(11'd20);
		`CHK("holiday", 3'b110, {armed, seen[11], seen[9]})
		clear();
		hol <= 0;
		minute(11'd15);
		`CHK("timer", 2'b11, {seen[12], seen[11]})
		clear();
		minute(11'd20);
		`CHK("nodis", 3'b110, {seen[9], armed, seen[1]})
		wreg(ADDR_CFG, 32'h00000100);
		minute(11'd15);
		clear();
		minute(11'd20);
		tick_en <= 1;
		while (seen[1] !== 1'b1 && cycles < 4000)
		begin
			@(posedge clk);
			#1;
		end
		tick_en <= 0;
		`CHK("disticks", 240, ticks)
		`CHK("autodis", 3'b110, {seen[8], seen[9], armed})
		summarize();
	end
endmodule // partition_arm_scheduler_tb
`default_nettype wire
